/* shared/acf_defs.svh */
// Constants of the angle timer capture/compare flag block.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
`ifndef ACF_DEFS_SVH
`define ACF_DEFS_SVH

// Register byte offsets.
`define ACF_ADR_FLAGS 8'h00
`define ACF_ADR_MASK 8'h04
`define ACF_ADR_MODE 8'h08
`define ACF_ADR_VAL1 8'h0C
`define ACF_ADR_VAL2 8'h10
`define ACF_ADR_VAL3 8'h14
`define ACF_ADR_PHASE 8'h18

// Channel count, implemented flag bits and reset values.
`define ACF_NCH 3
`define ACF_FLAGS_RST 3'h0
`define ACF_MASK_RST 3'h0
`define ACF_MODE_RST 3'h0
`define ACF_DAT_RST 32'h0000_0000
`define ACF_BIT_CH1 0
`define ACF_BIT_CH2 1
`define ACF_BIT_CH3 2

`endif

/* shared/acf_pkg.sv */
// Types shared by the capture/compare flag block.
// Assumes acf_defs.svh is on the include path.
`include "acf_defs.svh"

package acf_pkg;

    // One bit per channel.
    typedef logic [`ACF_NCH-1:0] acf_chan_vec_t;

    // Whole state of the top module.
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        acf_chan_vec_t flags;
        acf_chan_vec_t mask;
        acf_chan_vec_t mode;
        acf_chan_vec_t sync1;
        acf_chan_vec_t sync2;
        acf_chan_vec_t prev;
        logic irq;
    } acf_regs_t;

endpackage : acf_pkg

/* src/acf_chan.sv */
// One capture/compare channel: value register, capture and compare match.
// Assumes cap_pulse is already synchronised and phase_value is on ref_clk.
`timescale 1ns/1ps

module acf_chan #(
    parameter int PW = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic capture_select,
    input wire logic cap_pulse,
    input wire logic phase_tick,
    input wire logic [PW-1:0] phase_value,
    input wire logic wr_en,
    input wire logic [PW-1:0] wr_data,
    output logic [PW-1:0] value,
    output logic event_pulse
);
    import acf_pkg::*;

    typedef struct packed {
        logic [PW-1:0] value;
        logic evt;
    } acf_chan_state_t;

    acf_chan_state_t q;
    acf_chan_state_t d;

    // Capture latches the phase; compare fires when the phase reaches the value.
    always_comb
    begin
        d = q;
        d.evt = 1'b0;
        if (wr_en)
        begin
            d.value = wr_data;
        end
        if (capture_select)
        begin
            if (cap_pulse)
            begin
                d.value = phase_value; // [R01] [R05]
                d.evt = 1'b1; // [R01] [R05]
            end
        end
        else if (phase_tick && (phase_value == q.value))
        begin
            d.evt = 1'b1; // [R02] [R04] [R06]
        end
    end

    // State register.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign value = q.value;
    assign event_pulse = q.evt;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // A capture stores the phase seen on the capture cycle and raises the event.
    chk_cap_latch: assert property (capture_select && cap_pulse |=> event_pulse && value == $past(phase_value)) // [R01]
        else $error("capture did not latch phase");

    // A compare match raises the event one cycle later.
    chk_cmp_event: assert property (!capture_select && phase_tick && phase_value == value |=> event_pulse) // [R02]
        else $error("compare match lost");

    // An event has a cause of the selected kind.
    chk_evt_cause: assert property (event_pulse |-> $past(capture_select) ? $past(cap_pulse) : $past(phase_tick)) // [R03]
        else $error("event without cause of selected mode");

endmodule : acf_chan

/* src/acf_top.sv */
// Angle timer capture/compare flag register with a Wishbone slave port.
// Assumes phase_value and phase_tick on ref_clk; capture pins are asynchronous.
`timescale 1ns/1ps
`include "acf_defs.svh"

// Overview of operation
// [R01] Channel one in capture mode sets bit 0 and stores the phase.
// [R02] Channel one in compare mode sets bit 0 on a compare match.
// [R03] Channel two mode bit chooses capture (one) or compare (zero) flag meaning.
// [R04] Channel two in compare mode sets bit 1 on a compare match.
// [R05] Channel three in capture mode sets bit 2 and stores the phase.
// [R06] Channel three in compare mode sets bit 2 on a compare match.
// [R07] A zero flag means no event since clearing; writing zero clears it.
// [R08] Bits 7 to 3 read zero, ignore writes; flags reset to zero.
module acf_top #(
    parameter int PW = 16
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    input wire acf_pkg::acf_chan_vec_t capture_pin,
    input wire logic phase_tick,
    input wire logic [PW-1:0] phase_value
);
    import acf_pkg::*;

    acf_regs_t q;
    acf_regs_t d;
    logic req;
    logic wr;
    logic rd;
    acf_chan_vec_t cap_pulse;
    acf_chan_vec_t chan_evt;
    acf_chan_vec_t val_wr;
    acf_chan_vec_t clr;
    logic [PW-1:0] chan_val [`ACF_NCH];

    // True when the address selects the given register.
    function automatic logic acf_hit(input logic [7:0] adr, input logic [7:0] off);
        acf_hit = (adr == off);
    endfunction : acf_hit

    // Zero-extends a channel value to the bus width.
    function automatic logic [31:0] acf_ext(input logic [PW-1:0] v);
        acf_ext = 32'(v);
    endfunction : acf_ext

    // Bus strobes: a write lands on the edge that the master sees ack.
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & q.ack & wb_sel_i[0];
    assign rd = req & ~wb_we_i & ~q.ack;

    // Capture edges come from the second synchroniser stage only.
    assign cap_pulse = q.sync2 & ~q.prev;

    // Value register write strobes, one per channel.
    assign val_wr[0] = wr & acf_hit(wb_adr_i, `ACF_ADR_VAL1);
    assign val_wr[1] = wr & acf_hit(wb_adr_i, `ACF_ADR_VAL2);
    assign val_wr[2] = wr & acf_hit(wb_adr_i, `ACF_ADR_VAL3);

    // The three channels; the mode bit of each selects capture or compare.
    for (genvar i = 0; i < `ACF_NCH; i++)
    begin : g_chan
        acf_chan #(
            .PW(PW)
        ) u_chan (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .capture_select(q.mode[i]), // [R03]
            .cap_pulse(cap_pulse[i]),
            .phase_tick(phase_tick),
            .phase_value(phase_value),
            .wr_en(val_wr[i]),
            .wr_data(wb_dat_i[PW-1:0]),
            .value(chan_val[i]),
            .event_pulse(chan_evt[i])
        );
    end

    // Writing zero to a flag bit clears it; writing one leaves it alone.
    always_comb
    begin
        clr = '0;
        if (wr && acf_hit(wb_adr_i, `ACF_ADR_FLAGS))
        begin
            clr = ~wb_dat_i[`ACF_NCH-1:0]; // [R07]
        end
    end

    // Next state: bus handshake, synchronisers, flags, control and read data.
    always_comb
    begin
        d = q;
        d.ack = req & ~q.ack;
        d.sync1 = capture_pin;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        // A new event beats a clear in the same cycle.
        d.flags = (q.flags & ~clr) | chan_evt; // [R01] [R02] [R04] [R05] [R06] [R07]
        if (wr && acf_hit(wb_adr_i, `ACF_ADR_MASK))
        begin
            d.mask = wb_dat_i[`ACF_NCH-1:0];
        end
        if (wr && acf_hit(wb_adr_i, `ACF_ADR_MODE))
        begin
            d.mode = wb_dat_i[`ACF_NCH-1:0]; // [R03]
        end
        d.irq = |(d.flags & d.mask);
        d.dat = `ACF_DAT_RST;
        if (rd)
        begin
            unique case (wb_adr_i)
                `ACF_ADR_FLAGS: d.dat = 32'(q.flags); // [R08]
                `ACF_ADR_MASK: d.dat = 32'(q.mask);
                `ACF_ADR_MODE: d.dat = 32'(q.mode);
                `ACF_ADR_VAL1: d.dat = acf_ext(chan_val[0]);
                `ACF_ADR_VAL2: d.dat = acf_ext(chan_val[1]);
                `ACF_ADR_VAL3: d.dat = acf_ext(chan_val[2]);
                `ACF_ADR_PHASE: d.dat = acf_ext(phase_value);
                default: d.dat = `ACF_DAT_RST;
            endcase
        end
    end

    // State register; all flags clear at reset.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q.ack <= 1'b0;
            q.dat <= `ACF_DAT_RST;
            q.flags <= `ACF_FLAGS_RST; // [R08]
            q.mask <= `ACF_MASK_RST;
            q.mode <= `ACF_MODE_RST;
            q.sync1 <= '0;
            q.sync2 <= '0;
            q.prev <= '0;
            q.irq <= 1'b0;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from the state register.
    assign wb_dat_o = q.dat;
    assign wb_ack_o = q.ack;
    assign irq = q.irq;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // A capture on channel one: the edge, then the channel event, then the flag.
    sequence s_cap1;
        q.mode[`ACF_BIT_CH1] && cap_pulse[`ACF_BIT_CH1];
    endsequence

    sequence s_flag1_up;
        chan_evt[`ACF_BIT_CH1] ##1 q.flags[`ACF_BIT_CH1];
    endsequence

    chk_cap1_flag: assert property (s_cap1 |=> s_flag1_up) // [R01]
        else $error("channel one capture did not set flag");

    // A compare match on channel one sets the flag two cycles later.
    sequence s_cmp1;
        !q.mode[`ACF_BIT_CH1] && phase_tick && phase_value == chan_val[0];
    endsequence

    chk_cmp1_flag: assert property (s_cmp1 |-> ##2 q.flags[`ACF_BIT_CH1]) // [R02]
        else $error("channel one compare did not set flag");

    // Channel two in capture mode ignores compare matches.
    chk_mode2_sel: assert property (q.mode[`ACF_BIT_CH2] && !cap_pulse[`ACF_BIT_CH2] |=> !chan_evt[`ACF_BIT_CH2]) // [R03]
        else $error("channel two event outside its mode");

    // A compare match on channel two sets its flag.
    chk_cmp2_flag: assert property (!q.mode[`ACF_BIT_CH2] && phase_tick && phase_value == chan_val[1] // [R04]
        |-> ##2 q.flags[`ACF_BIT_CH2])
        else $error("channel two compare did not set flag");

    // A capture on channel three stores the phase and sets the flag.
    chk_cap3_flag: assert property (q.mode[`ACF_BIT_CH3] && cap_pulse[`ACF_BIT_CH3] // [R05]
        |=> chan_val[2] == $past(phase_value) ##1 q.flags[`ACF_BIT_CH3])
        else $error("channel three capture lost");

    // A compare match on channel three sets the flag.
    chk_cmp3_flag: assert property (!q.mode[`ACF_BIT_CH3] && phase_tick && phase_value == chan_val[2] // [R06]
        |-> ##2 q.flags[`ACF_BIT_CH3])
        else $error("channel three compare did not set flag");

    // Writing zero clears a flag unless an event arrives in the same cycle.
    chk_flag_clear: assert property (wr && acf_hit(wb_adr_i, `ACF_ADR_FLAGS) // [R07]
        && !wb_dat_i[`ACF_BIT_CH1] |=> q.flags[`ACF_BIT_CH1] == $past(chan_evt[`ACF_BIT_CH1]))
        else $error("flag clear or set-wins wrong");

    // A flag only rises because its channel reported an event.
    chk_flag_cause: assert property ($rose(q.flags[`ACF_BIT_CH2]) |-> $past(chan_evt[`ACF_BIT_CH2])) // [R07]
        else $error("flag rose without event");

    // A flags read shows zero in every unimplemented bit.
    sequence s_rd_flags;
        rd && acf_hit(wb_adr_i, `ACF_ADR_FLAGS);
    endsequence

    chk_upper_zero: assert property (s_rd_flags |=> q.ack && q.dat[31:`ACF_NCH] == '0 // [R08]
        && q.dat[`ACF_NCH-1:0] == $past(q.flags))
        else $error("flag read upper bits not zero");

    // The interrupt follows the masked flags.
    chk_irq_level: assert property (irq == |(q.flags & q.mask))
        else $error("interrupt level mismatch");

    // Ack lasts exactly one cycle.
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");

    // A request taken with ack low is answered on the next edge.
    chk_ack_timing: assert property (req && !q.ack |=> wb_ack_o)
        else $error("ack did not follow request");

    // Read data stands only with ack and is zero otherwise.
    chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == `ACF_DAT_RST)
        else $error("read data outside ack");

    // A capture on channel two: the edge, then the channel event, then the flag.
    sequence s_cap2;
        q.mode[`ACF_BIT_CH2] && cap_pulse[`ACF_BIT_CH2];
    endsequence

    sequence s_flag2_up;
        chan_evt[`ACF_BIT_CH2] ##1 q.flags[`ACF_BIT_CH2];
    endsequence

    chk_cap2_flag: assert property (s_cap2 |=> s_flag2_up) // [R03]
        else $error("channel two capture did not set flag");

    // Captures on channels one and two store the phase of the capture cycle.
    chk_cap1_value: assert property (s_cap1 |=> chan_val[0] == $past(phase_value)) // [R01]
        else $error("channel one capture value wrong");

    chk_cap2_value: assert property (s_cap2 |=> chan_val[1] == $past(phase_value)) // [R03]
        else $error("channel two capture value wrong");

    // A compare channel with no phase step stays quiet, whatever its pin does.
    chk_mode1_sel: assert property (!q.mode[`ACF_BIT_CH1] && !phase_tick |=> !chan_evt[`ACF_BIT_CH1]) // [R02]
        else $error("channel one event outside its mode");

    chk_mode3_sel: assert property (!q.mode[`ACF_BIT_CH3] && !phase_tick |=> !chan_evt[`ACF_BIT_CH3]) // [R06]
        else $error("channel three event outside its mode");

    // A capture channel with no capture edge stays quiet, whatever the phase does.
    chk_cap3_sel: assert property (q.mode[`ACF_BIT_CH3] && !cap_pulse[`ACF_BIT_CH3] // [R05]
        |=> !chan_evt[`ACF_BIT_CH3])
        else $error("channel three event without capture");

    // A set flag holds until software writes zero to it.
    chk_flag1_hold: assert property (q.flags[`ACF_BIT_CH1] // [R07]
        && !(wr && acf_hit(wb_adr_i, `ACF_ADR_FLAGS) && !wb_dat_i[`ACF_BIT_CH1]) |=> q.flags[`ACF_BIT_CH1])
        else $error("channel one flag lost without clear");

    chk_flag2_hold: assert property (q.flags[`ACF_BIT_CH2] // [R07]
        && !(wr && acf_hit(wb_adr_i, `ACF_ADR_FLAGS) && !wb_dat_i[`ACF_BIT_CH2]) |=> q.flags[`ACF_BIT_CH2])
        else $error("channel two flag lost without clear");

    // Writing zero clears channel three too, unless its event arrives in that cycle.
    chk_flag3_clear: assert property (wr && acf_hit(wb_adr_i, `ACF_ADR_FLAGS) && !wb_dat_i[`ACF_BIT_CH3] // [R07]
        |=> q.flags[`ACF_BIT_CH3] == $past(chan_evt[`ACF_BIT_CH3]))
        else $error("channel three flag clear wrong");

    // Flags of channels one and three only rise because their channel reported an event.
    chk_flag1_cause: assert property ($rose(q.flags[`ACF_BIT_CH1]) |-> $past(chan_evt[`ACF_BIT_CH1])) // [R07]
        else $error("channel one flag rose without event");

    chk_flag3_cause: assert property ($rose(q.flags[`ACF_BIT_CH3]) |-> $past(chan_evt[`ACF_BIT_CH3])) // [R07]
        else $error("channel three flag rose without event");

    // Mask and mode writes land on the acknowledged edge.
    chk_mask_write: assert property (wr && acf_hit(wb_adr_i, `ACF_ADR_MASK)
        |=> q.mask == $past(wb_dat_i[`ACF_NCH-1:0]))
        else $error("mask write lost");

    chk_mode_write: assert property (wr && acf_hit(wb_adr_i, `ACF_ADR_MODE) // [R03]
        |=> q.mode == $past(wb_dat_i[`ACF_NCH-1:0]))
        else $error("mode write lost");

    // A value write without a capture in the same cycle stores the bus data.
    chk_val1_write: assert property (wr && acf_hit(wb_adr_i, `ACF_ADR_VAL1) && !cap_pulse[`ACF_BIT_CH1]
        |=> chan_val[0] == $past(wb_dat_i[PW-1:0]))
        else $error("channel one value write lost");

    chk_val2_write: assert property (wr && acf_hit(wb_adr_i, `ACF_ADR_VAL2) && !cap_pulse[`ACF_BIT_CH2]
        |=> chan_val[1] == $past(wb_dat_i[PW-1:0]))
        else $error("channel two value write lost");

    chk_val3_write: assert property (wr && acf_hit(wb_adr_i, `ACF_ADR_VAL3) && !cap_pulse[`ACF_BIT_CH3]
        |=> chan_val[2] == $past(wb_dat_i[PW-1:0]))
        else $error("channel three value write lost");

endmodule : acf_top

/* bench/tb_top.sv */
// Self-checking bench for the capture/compare flag block.
// Assumes acf_top with a classic Wishbone port and the register map of acf_defs.svh.
`timescale 1ns/1ps
`include "acf_defs.svh"

module tb_top;
    import acf_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack, irq;
    acf_chan_vec_t pins = 3'h0;
    logic [15:0] phase = 16'h0000, ph, c;
    logic [31:0] exp_q[$];
    string name_q[$];
    int error_cnt = 0, checks_done = 0, cycles = 0;

    acf_top #(.PW(16)) DUT (.ref_clk(ref_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq(irq),
        .capture_pin(pins), .phase_tick(tick), .phase_value(phase));

    // Clock at 125 MHz.
    always #4 ref_clk = ~ref_clk;

    // Compares one value and counts the outcome.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One classic Wishbone cycle; a read leaves its expected value in the queue.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input string n = "");
        int k;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'h1;
        if (!w)
        begin
            exp_q.push_back(d);
            name_q.push_back(n);
        end
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (ack !== 1'b1 && k < 20);
        if (k >= 20)
            chk("ack wait", 32'h1, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    // Watches read answers and compares each with the oldest note.
    always @(posedge ref_clk)
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
            chk(name_q.pop_front(), exp_q.pop_front(), dat_o);

    // Rising edge on one capture pin, held long enough for the synchroniser.
    task automatic cap(input int i);
        @(posedge ref_clk);
        pins[i] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        pins[i] <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask : cap

    // One phase step at value v, then the phase moves away.
    task automatic step(input logic [15:0] v);
        @(posedge ref_clk);
        phase <= v;
        tick <= 1'b1;
        @(posedge ref_clk);
        tick <= 1'b0;
        phase <= ~v;
        repeat (5) @(posedge ref_clk);
    endtask : step

    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // Cuts a hang short.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            summarize();
        end
    end

    // Main sequence.
    initial
    begin
        void'($urandom(32'he072));
        ph = 16'($urandom());
        c = ph ^ 16'h5A5A;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        wb(0, `ACF_ADR_FLAGS, 32'h0000_0000, "flags reset");
        wb(0, `ACF_ADR_MASK, 32'h0000_0000, "mask reset");
        wb(0, `ACF_ADR_MODE, 32'h0000_0000, "mode reset");
        wb(1, `ACF_ADR_FLAGS, 32'hFFFF_FFFF);
        wb(0, `ACF_ADR_FLAGS, 32'h0000_0000, "flags after ones");
        wb(0, 8'h40, 32'h0000_0000, "unmapped");
        // Channels one and three capture, channel two compares.
        wb(1, `ACF_ADR_MODE, 32'h0000_0005);
        phase <= ph;
        cap(0);
        cap(2);
        cap(1);
        wb(0, `ACF_ADR_FLAGS, 32'h0000_0005, "flags capture");
        wb(0, `ACF_ADR_VAL1, {16'h0000, ph}, "value one");
        wb(0, `ACF_ADR_VAL3, {16'h0000, ph}, "value three");
        wb(1, `ACF_ADR_VAL2, {16'h0000, c});
        step(c);
        wb(0, `ACF_ADR_FLAGS, 32'h0000_0007, "flags compare two");
        wb(1, `ACF_ADR_MASK, 32'h0000_0002);
        repeat (2) @(posedge ref_clk);
        chk("irq set", 32'h1, {31'h0, irq});
        wb(1, `ACF_ADR_FLAGS, 32'h0000_0005);
        wb(0, `ACF_ADR_FLAGS, 32'h0000_0005, "flags clear two");
        chk("irq clear", 32'h0, {31'h0, irq});
        wb(1, `ACF_ADR_FLAGS, 32'h0000_0000);
        // Channel two capture, others compare.
        wb(1, `ACF_ADR_MODE, 32'h0000_0002);
        phase <= ph;
        cap(1);
        wb(0, `ACF_ADR_FLAGS, 32'h0000_0002, "flags capture two");
        wb(0, `ACF_ADR_VAL2, {16'h0000, ph}, "value two");
        wb(1, `ACF_ADR_FLAGS, 32'h0000_0000);
        wb(1, `ACF_ADR_MODE, 32'h0000_0000);
        wb(1, `ACF_ADR_VAL1, {16'h0000, c ^ 16'h0011});
        wb(1, `ACF_ADR_VAL3, {16'h0000, c ^ 16'h0022});
        cap(0);
        wb(0, `ACF_ADR_FLAGS, 32'h0000_0000, "capture in compare");
        step(c ^ 16'h0011);
        wb(0, `ACF_ADR_FLAGS, 32'h0000_0001, "flags compare one");
        step(c ^ 16'h0022);
        wb(0, `ACF_ADR_FLAGS, 32'h0000_0005, "flags compare three");
        wb(0, `ACF_ADR_VAL1, {16'h0000, c ^ 16'h0011}, "value one kept");
        // A reset in mid-run, with flags set, must clear flags and values again.
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        wb(0, `ACF_ADR_FLAGS, 32'h0000_0000, "flags after reset");
        wb(0, `ACF_ADR_VAL1, 32'h0000_0000, "value after reset");
        wb(0, `ACF_ADR_MASK, 32'h0000_0000, "mask after reset");
        chk("irq after reset", 32'h0, {31'h0, irq});
        repeat (3) @(posedge ref_clk);
        chk("notes left", 32'h0, 32'(exp_q.size()));
        summarize();
    end
endmodule : tb_top
